//--- logic/rst_defines.svh
// Constants for the reset controller: register offsets, field positions, reset values, timing.
`ifndef RST_DEFINES_SVH
`define RST_DEFINES_SVH
`define OFS_PMODE0 12'h004
`define OFS_PMODE1 12'h005
`define OFS_CMODE2 12'h006
`define OFS_MODEDEP 12'h008
`define OFS_STATUS 12'h00C
`define ADDR_PMODE0 12'h010
`define ADDR_PMODE1 12'h014
`define ADDR_CMODE2 12'h018
`define ADDR_MODEDEP 12'h020
`define ADDR_STATUS 12'h030
`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_PROG_RST 3
`define BIT_WDT_SEL 2
`define BIT_OSC_ACT 7
`define BIT_RAM_UNDEF 4
`define PMODE0_RST_LO 8'h00
`define PMODE0_RST_HI 8'h03
`define PMODE1_RST 8'h08
`define CMODE2_RST 8'h00
`define MODEDEP_SINGLE 8'h00
`define MODEDEP_EXP 8'h02
`define PIN_MIN_CYCLES 5'd20
`define RST_HOLD_CYCLES 4'd8
`define SETTLE_CYCLES 8'd100
`endif

//--- logic/rst_pkg.sv
// Types shared by the reset controller files.
package rst_pkg;
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_PIN_LOW = 3'b001,
    ST_APPLY = 3'b010,
    ST_RUN = 3'b011,
    ST_HALT = 3'b100
  } rst_state_e;
  typedef enum logic [1:0] {
    CAUSE_PIN = 2'b00,
    CAUSE_PROG = 2'b01,
    CAUSE_WDT = 2'b10,
    CAUSE_OSC = 2'b11
  } rst_cause_e;
endpackage

//--- logic/rst_src_if.sv
// Reset source bundle between the top and the pin synchroniser.
`timescale 1ns/1ps
interface rst_src_if;
  logic raw_n;
  logic sync_n;
  modport sync (input raw_n, output sync_n);
  modport user (output raw_n, input sync_n);
endinterface

//--- logic/rst_pin_sync.sv
// Three-stage synchroniser for the external reset pin.
`timescale 1ns/1ps
module rst_pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin
  rst_src_if.sync src
);
  logic s1;
  logic s2;
  logic s3;
  logic level;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= src.raw_n;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // The level only moves once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
  assign src.sync_n = level;
endmodule

//--- logic/mcu_reset_controller.sv
// Reset controller merging pin, program, watchdog and oscillator-stop resets.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "rst_defines.svh"
// Function
// - Four reset causes: pin, program, watchdog, oscillator.
// - Pin low resets pins and oscillator.
// - Pin rise initialises core, then fetch vector.
// - Internal RAM is never cleared by reset.
// - Writing program reset bit restarts device.
// - Program reset bit always reads zero.
// - Watchdog underflow resets when select bit set.
// - Oscillator stop resets and halts when action zero.
// - Non-pin resets keep some registers unchanged.
// - Non-pin resets keep processor mode bits.
// - Mode-dependent register reset value follows mode.
// - Boot pin high: hold ack follows request.
// - Boot pin high: pins undefined until settled.
module mcu_reset_controller (
  // Clock and bus reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic ext_reset_n,
  input wire logic boot_mode_pin,
  input wire logic hold_req,
  output logic hold_ack_out,
  // Event inputs from neighbouring blocks
  input wire logic wdt_underflow,
  input wire logic osc_stop_detect,
  input wire logic ram_write_busy,
  // Reset and status outputs
  output logic pin_reset_state,
  output logic osc_reset,
  output logic core_reset,
  output logic core_halt,
  output logic fetch_vector,
  output logic pins_defined,
  output logic ram_undefined,
  output rst_pkg::rst_cause_e last_cause
);
  import rst_pkg::*;

  rst_src_if pin_if ();
  rst_state_e state;
  rst_state_e next_state;
  logic [7:0] processor_mode_reg0;
  logic [7:0] processor_mode_reg1;
  logic [7:0] clock_mode_reg2;
  logic [7:0] mode_dep_reg;
  logic [4:0] pin_cnt;
  logic [3:0] hold_cnt;
  logic [7:0] settle_cnt;
  logic boot_hi;
  logic prog_req;
  logic wdt_req;
  logic osc_req;
  logic soft_req;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign pin_if.raw_n = ext_reset_n;

  rst_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .src(pin_if)
  );

  function automatic logic [7:0] mode_dep_value(input logic [1:0] mode);
    mode_dep_value = (mode == 2'b00) ? `MODEDEP_SINGLE : `MODEDEP_EXP;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  // APB decode; the slave always answers in the first access cycle.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign addr_ok = hit(paddr, `ADDR_PMODE0) || hit(paddr, `ADDR_PMODE1) ||
                   hit(paddr, `ADDR_CMODE2) || hit(paddr, `ADDR_MODEDEP) ||
                   hit(paddr, `ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  assign prog_req = wr_en && hit(paddr, `ADDR_PMODE0) && pwdata[`BIT_PROG_RST] &&
                    state == ST_RUN;
  assign wdt_req = wdt_underflow && processor_mode_reg1[`BIT_WDT_SEL] &&
                   state == ST_RUN;
  assign osc_req = osc_stop_detect && !clock_mode_reg2[`BIT_OSC_ACT] &&
                   state == ST_RUN;
  assign soft_req = prog_req || wdt_req || osc_req;

  // Boot pin level is captured by a clocked process while in ST_PIN_LOW.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_hi <= 1'b0;
    end else if (state == ST_PIN_LOW) begin
      boot_hi <= boot_mode_pin;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_SETTLE: begin
        if (settle_cnt == `SETTLE_CYCLES) begin
          next_state = ST_PIN_LOW;
        end
      end
      ST_PIN_LOW: begin
        if (pin_if.sync_n && pin_cnt >= `PIN_MIN_CYCLES) begin
          next_state = ST_APPLY;
        end
      end
      ST_APPLY: begin
        if (hold_cnt == `RST_HOLD_CYCLES) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (osc_req) begin
          next_state = ST_HALT;
        end else if (soft_req) begin
          next_state = ST_APPLY;
        end
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
    if (!pin_if.sync_n && state != ST_SETTLE) begin
      next_state = ST_PIN_LOW;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 8'h00;
    end else if (state == ST_SETTLE && settle_cnt != `SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 8'h01;
    end
  end

  // Counts main clock cycles spent in ST_PIN_LOW, whatever the pin level; saturates at PIN_MIN_CYCLES.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cnt <= 5'h00;
    end else if (state != ST_PIN_LOW) begin
      pin_cnt <= 5'h00;
    end else if (pin_cnt != `PIN_MIN_CYCLES) begin
      pin_cnt <= pin_cnt + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 4'h0;
    end else if (state != ST_APPLY) begin
      hold_cnt <= 4'h0;
    end else begin
      hold_cnt <= hold_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cause <= CAUSE_PIN;
    end else if (state == ST_PIN_LOW) begin
      last_cause <= CAUSE_PIN;
    end else if (state == ST_RUN) begin
      if (osc_req) begin
        last_cause <= CAUSE_OSC;
      end else if (wdt_req) begin
        last_cause <= CAUSE_WDT;
      end else if (prog_req) begin
        last_cause <= CAUSE_PROG;
      end
    end
  end

  // Mode register 0: pin reset loads from the boot pin, other resets keep mode bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_mode_reg0 <= `PMODE0_RST_LO;
    end else if (state == ST_PIN_LOW) begin
      processor_mode_reg0 <= boot_mode_pin ? `PMODE0_RST_HI : `PMODE0_RST_LO;
    end else if (state == ST_APPLY && hold_cnt == 4'h0 && last_cause != CAUSE_PIN) begin
      processor_mode_reg0 <= {6'h00, processor_mode_reg0[`BIT_MODE_HI:`BIT_MODE_LO]};
    end else if (state == ST_RUN && wr_en && hit(paddr, `ADDR_PMODE0)) begin
      processor_mode_reg0 <= pwdata[7:0] & ~(8'h01 << `BIT_PROG_RST);
    end
  end

  // Watchdog select can only be set by software; software cannot clear it, only a pin reset does.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_mode_reg1 <= `PMODE1_RST;
    end else if (state == ST_PIN_LOW) begin
      processor_mode_reg1 <= `PMODE1_RST;
    end else if (state == ST_RUN && wr_en && hit(paddr, `ADDR_PMODE1)) begin
      processor_mode_reg1 <= pwdata[7:0] | (processor_mode_reg1 & (8'h01 << `BIT_WDT_SEL));
    end
  end

  // Clock mode register is kept across non-pin resets.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_mode_reg2 <= `CMODE2_RST;
    end else if (state == ST_PIN_LOW) begin
      clock_mode_reg2 <= `CMODE2_RST;
    end else if (state == ST_RUN && wr_en && hit(paddr, `ADDR_CMODE2)) begin
      clock_mode_reg2 <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_dep_reg <= `MODEDEP_SINGLE;
    end else if (state == ST_PIN_LOW) begin
      mode_dep_reg <= boot_mode_pin ? `MODEDEP_EXP : `MODEDEP_SINGLE;
    end else if (state == ST_APPLY && hold_cnt == 4'h0 && last_cause != CAUSE_PIN) begin
      mode_dep_reg <= mode_dep_value(processor_mode_reg0[`BIT_MODE_HI:`BIT_MODE_LO]);
    end else if (state == ST_RUN && wr_en && hit(paddr, `ADDR_MODEDEP)) begin
      mode_dep_reg <= pwdata[7:0];
    end
  end

  // A reset that lands in ST_RUN during a RAM write marks RAM content as undefined;
  // RAM itself is never cleared here, and software clears the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_undefined <= 1'b0;
    end else if ((soft_req || (!pin_if.sync_n && state == ST_RUN)) && ram_write_busy) begin
      ram_undefined <= 1'b1;
    end else if (wr_en && hit(paddr, `ADDR_STATUS) && pwdata[`BIT_RAM_UNDEF]) begin
      ram_undefined <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata <= 32'h0000_0000;
      if (hit(paddr, `ADDR_PMODE0)) begin
        prdata[7:0] <= processor_mode_reg0;
      end else if (hit(paddr, `ADDR_PMODE1)) begin
        prdata[7:0] <= processor_mode_reg1;
      end else if (hit(paddr, `ADDR_CMODE2)) begin
        prdata[7:0] <= clock_mode_reg2;
      end else if (hit(paddr, `ADDR_MODEDEP)) begin
        prdata[7:0] <= mode_dep_reg;
      end else if (hit(paddr, `ADDR_STATUS)) begin
        prdata[7:0] <= {3'b000, ram_undefined, boot_hi, state};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_vector <= 1'b0;
    end else begin
      fetch_vector <= (state == ST_APPLY) && (next_state == ST_RUN);
    end
  end

  assign pin_reset_state = (state == ST_PIN_LOW) || (state == ST_SETTLE) ||
                           (state == ST_APPLY) || (state == ST_HALT);
  assign osc_reset = (state == ST_PIN_LOW) || (state == ST_SETTLE);
  assign core_reset = (state != ST_RUN);
  assign core_halt = (state == ST_HALT);
  assign pins_defined = !(boot_mode_pin && state == ST_SETTLE);
  assign hold_ack_out = boot_mode_pin ? hold_req : 1'b0;
endmodule

//--- tb/mcu_reset_controller_assertions.sv
// Port checker for the reset controller.
`timescale 1ns/1ps
`include "rst_defines.svh"
module mcu_reset_controller_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Pins
  input wire logic ext_reset_n,
  input wire logic boot_mode_pin,
  input wire logic hold_req,
  input wire logic hold_ack_out,
  // Reset outputs
  input wire logic pin_reset_state,
  input wire logic osc_reset,
  input wire logic core_reset,
  input wire logic core_halt,
  input wire logic fetch_vector,
  input wire logic pins_defined
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; hold_ack_out == (boot_mode_pin && hold_req); endproperty
  a_hold: assert property (p_hold) else $error("hold ack wrong");
  property p_defined; !boot_mode_pin |-> pins_defined; endproperty
  a_defined: assert property (p_defined) else $error("pins undefined");
  property p_osc; osc_reset |-> pin_reset_state && core_reset; endproperty
  a_osc: assert property (p_osc) else $error("osc reset alone");
  // The pin passes a three-flop synchroniser, a level flop and the state register, so six low samples are just enough.
  property p_pin; !ext_reset_n [*6] |-> pin_reset_state && core_reset && !fetch_vector; endproperty
  a_pin: assert property (p_pin) else $error("pin low not obeyed");
  property p_pulse; fetch_vector |=> !fetch_vector; endproperty
  a_pulse: assert property (p_pulse) else $error("fetch too long");
  property p_exit; $fell(core_reset) |-> ##[0:1] fetch_vector; endproperty
  a_exit: assert property (p_exit) else $error("no fetch");
  property p_prog;
    psel && penable && pwrite && paddr == `ADDR_PMODE0 && pwdata[`BIT_PROG_RST] && !core_reset
      |-> ##2 core_reset [*6];
  endproperty
  a_prog: assert property (p_prog) else $error("no program reset");
  property p_halt; core_halt |-> core_reset; endproperty
  a_halt: assert property (p_halt) else $error("halt out of reset");
  property p_halt_keep; ext_reset_n [*8] ##0 core_halt |=> core_halt; endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("halt left");
  c_fetch: cover property (fetch_vector);
  c_halt: cover property ($rose(core_halt));
  c_err: cover property (pslverr);
endmodule
bind mcu_reset_controller mcu_reset_controller_assertions u_chk (.*);

//--- tb/ext_reset_model.sv
// Model of the external reset circuit driving the reset pin.
`timescale 1ns/1ps
module ext_reset_model #(
  parameter int LOW_CYCLES = 20,
  parameter int POWER_WAIT = 130
) (
  // Clock
  input wire logic pclk,
  // Control
  input wire logic reset_req,
  // Pin
  output logic ext_reset_n
);
  // Power-up low time covers supply settling plus the minimum clocks.
  int cnt = POWER_WAIT;
  initial ext_reset_n = 1'b0;
  always @(posedge pclk) begin
    if (reset_req) begin
      ext_reset_n <= 1'b0;
      cnt <= LOW_CYCLES;
    end else if (cnt > 0)
      cnt <= cnt - 1;
    else
      ext_reset_n <= 1'b1;
  end
endmodule

//--- tb/mcu_reset_controller_test.sv
// Self-checking bench for the reset controller.
`timescale 1ns/1ps
`include "rst_defines.svh"
module mcu_reset_controller_test;
  import rst_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, ext_reset_n, boot_mode_pin = 0, hold_req = 0, hold_ack_out;
  logic wdt_underflow = 0, osc_stop_detect = 0, ram_write_busy = 0, reset_req = 0;
  logic pin_reset_state, osc_reset, core_reset, core_halt, fetch_vector, pins_defined;
  logic ram_undefined;
  rst_cause_e last_cause;
  int fails = 0, tests_run = 0;
  always #5 pclk = ~pclk;
  ext_reset_model u_ext (
    .pclk(pclk),
    .reset_req(reset_req),
    .ext_reset_n(ext_reset_n)
  );
  mcu_reset_controller u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ext_reset_n(ext_reset_n),
    .boot_mode_pin(boot_mode_pin),
    .hold_req(hold_req),
    .hold_ack_out(hold_ack_out),
    .wdt_underflow(wdt_underflow),
    .osc_stop_detect(osc_stop_detect),
    .ram_write_busy(ram_write_busy),
    .pin_reset_state(pin_reset_state),
    .osc_reset(osc_reset),
    .core_reset(core_reset),
    .core_halt(core_halt),
    .fetch_vector(fetch_vector),
    .pins_defined(pins_defined),
    .ram_undefined(ram_undefined),
    .last_cause(last_cause)
  );
  task automatic check(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) fails++;
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_fetch();
    int n;
    n = 0;
    while (fetch_vector !== 1 && n < 3000) begin
      @(posedge pclk);
      #1 n++;
    end
    if (n == 3000) fails++;
    // Return on a rising edge so that the caller drives inputs on the edge.
    @(posedge pclk);
  endtask
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    wait_fetch();
    check("cause", last_cause, CAUSE_PIN);
    apb(0, `ADDR_PMODE0, 0);
    check("pmode0", rd, 32'h0);
    apb(0, `ADDR_PMODE1, 0);
    check("pmode1", rd, `PMODE1_RST);
    apb(0, `ADDR_MODEDEP, 0);
    check("modedep", rd, 32'h0);
    apb(0, 12'h040, 0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1, `ADDR_PMODE0, 32'h1);
    apb(1, `ADDR_PMODE0, 32'h9);
    wait_fetch();
    check("cause", last_cause, CAUSE_PROG);
    apb(0, `ADDR_PMODE0, 0);
    check("pmode0", rd, 32'h1);
    apb(0, `ADDR_MODEDEP, 0);
    check("modedep", rd, 32'h2);
    // An underflow with the select bit clear must only interrupt, never reset.
    @(posedge pclk) wdt_underflow <= 1;
    @(posedge pclk) wdt_underflow <= 0;
    repeat (5) @(posedge pclk);
    check("no wdt", core_reset, 0);
    apb(1, `ADDR_PMODE1, 32'hC);
    @(posedge pclk) wdt_underflow <= 1;
    @(posedge pclk) wdt_underflow <= 0;
    wait_fetch();
    check("cause", last_cause, CAUSE_WDT);
    apb(0, `ADDR_PMODE1, 0);
    check("pmode1", rd, 32'hC);
    apb(1, `ADDR_CMODE2, 32'h80);
    @(posedge pclk) osc_stop_detect <= 1;
    @(posedge pclk) osc_stop_detect <= 0;
    repeat (5) @(posedge pclk);
    check("osc off", core_reset, 0);
    apb(1, `ADDR_CMODE2, 32'h0);
    @(posedge pclk) osc_stop_detect <= 1;
    @(posedge pclk) osc_stop_detect <= 0;
    repeat (5) @(posedge pclk);
    check("halt", core_halt, 1);
    check("cause", last_cause, CAUSE_OSC);
    // Only a pin reset leaves the halt; the RAM hazard needs a running core.
    @(posedge pclk) reset_req <= 1;
    @(posedge pclk) reset_req <= 0;
    wait_fetch();
    check("cause", last_cause, CAUSE_PIN);
    check("ram", ram_undefined, 0);
    apb(0, `ADDR_PMODE1, 0);
    check("pmode1", rd, `PMODE1_RST);
    ram_write_busy <= 1;
    @(posedge pclk) reset_req <= 1;
    @(posedge pclk) reset_req <= 0;
    wait_fetch();
    ram_write_busy <= 0;
    check("ram", ram_undefined, 1);
    check("cause", last_cause, CAUSE_PIN);
    apb(0, `ADDR_STATUS, 0);
    check("status", rd, {27'h000_0000, 1'b1, 1'b0, ST_RUN});
    apb(1, `ADDR_STATUS, 32'h0000_0010);
    @(posedge pclk);
    check("ram clr", ram_undefined, 0);
    {boot_mode_pin, hold_req} <= 2'b01;
    @(posedge pclk);
    check("hold", hold_ack_out, 0);
    {boot_mode_pin, hold_req} <= 2'b11;
    @(posedge pclk);
    check("hold", hold_ack_out, 1);
    {boot_mode_pin, hold_req} <= 2'b10;
    @(posedge pclk);
    check("hold", hold_ack_out, 0);
    // A second power-up, now with the boot pin high.
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    check("defined", pins_defined, 0);
    wait_fetch();
    check("defined", pins_defined, 1);
    check("cause", last_cause, CAUSE_PIN);
    apb(0, `ADDR_PMODE0, 0);
    check("pmode0", rd, `PMODE0_RST_HI);
    apb(0, `ADDR_MODEDEP, 0);
    check("modedep", rd, `MODEDEP_EXP);
    apb(0, `ADDR_STATUS, 0);
    check("status", rd, {27'h000_0000, 1'b0, 1'b1, ST_RUN});
    give_verdict();
  end
endmodule
